// File: trip_pkg.sv
/*
 * Shared definitions for the trip and alarm supervisor: register map,
 * control bit positions, trip classes, priorities and timing constants.
 * Assumes a 250 MHz system clock and an APB master with 32-bit data.
 */
package trip_pkg;
	// Register byte offsets on the APB window.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_RESET = 8'h08;
	localparam logic [7:0] ADDR_DEFAULTS = 8'h0C;
	localparam logic [7:0] ADDR_ALARMS = 8'h10;
	// Control register bit positions.
	localparam int CTRL_STOP_FIRST = 0;
	localparam int CTRL_LV_MODE = 1;
	localparam int CTRL_POWER_UP = 2;
	localparam int CTRL_EDITING = 3;
	localparam int CTRL_SUPPLY_SEL = 4;
	localparam int CTRL_PLC_RUN = 5;
	localparam int CTRL_DRIVE_EN = 6;
	localparam int CTRL_W = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 7'h00;
	// Reset register: bit position of the reset request.
	localparam int RST_REQ_BIT = 0;
	// Value that must be written to the defaults register to arm a reset.
	localparam logic [15:0] LOAD_DEFAULTS_CODE = 16'h03E8;
	// Trip classes as presented by the drive firmware.
	typedef enum logic [3:0] {
		CL_HW = 4'h0,
		CL_NONRES = 4'h1,
		CL_MEM = 4'h2,
		CL_CARD = 4'h3,
		CL_ENC_SUPPLY = 4'h4,
		CL_ENC_MINOR = 4'h5,
		CL_EXT_RESET = 4'h6,
		CL_NORMAL = 4'h7,
		CL_NONIMP = 4'h8,
		CL_PHASE = 4'h9,
		CL_OVERHEAT = 4'hA,
		CL_UV = 4'hB
	} trip_class_t;
	// Priority numbers: smaller is more important.
	localparam logic [2:0] PRIO_HW = 3'h1;
	localparam logic [2:0] PRIO_NONRES = 3'h2;
	localparam logic [2:0] PRIO_MEM = 3'h3;
	localparam logic [2:0] PRIO_CARD = 3'h4;
	localparam logic [2:0] PRIO_NORMAL = 3'h5;
	localparam logic [2:0] PRIO_UV = 3'h6;
	localparam logic [2:0] PRIO_NONE = 3'h7;
	// Code shown for the under-voltage trip.
	localparam logic [7:0] UV_CODE = 8'h01;
	// Timing figures in milliseconds and the clock rate.
	localparam longint unsigned CLK_KHZ = 64'd250000;
	localparam longint unsigned RESET_DELAY_MS = 64'd1000;
	localparam longint unsigned EXT_RESET_DELAY_MS = 64'd10000;
	localparam longint unsigned STOP_TIMEOUT_MS = 64'd10000;
	localparam longint unsigned FLASH_MS = 64'd640;
	localparam longint unsigned PLC_FLASH_MS = 64'd10000;
	localparam longint unsigned RESET_DELAY_CYC = RESET_DELAY_MS * CLK_KHZ;
	localparam longint unsigned EXT_RESET_DELAY_CYC = EXT_RESET_DELAY_MS * CLK_KHZ;
	localparam longint unsigned STOP_TIMEOUT_CYC = STOP_TIMEOUT_MS * CLK_KHZ;
	localparam longint unsigned FLASH_CYC = FLASH_MS * CLK_KHZ;
	localparam longint unsigned PLC_FLASH_CYC = PLC_FLASH_MS * CLK_KHZ;
	// Alarm threshold is 75 %: acc * 4 >= limit * 3.
	localparam logic [2:0] ALARM_NUM = 3'h3;
	localparam logic [2:0] ALARM_DEN = 3'h4;
	// Bus carriers.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
	// A fault report from the drive, one-cycle valid.
	typedef struct packed {
		logic valid;
		trip_class_t cls;
		logic [7:0] code;
	} fault_t;
	// Drive plant conditions, levels.
	typedef struct packed {
		logic dc_bus_ok;
		logic motor_stopped;
		logic brake_active;
		logic drive_loaded;
		logic limit_active;
		logic [15:0] brake_acc;
		logic [15:0] brake_limit;
		logic [15:0] motor_acc;
		logic [15:0] motor_limit;
	} plant_t;
endpackage : trip_pkg

// File: trip_priority_alarm_manager.sv
/*
 * Trip and alarm supervisor: latches the most important trip, enforces
 * reset rules per category, runs the self-resetting under-voltage trip
 * and sequences flashing alarm indications.
 * Assumes fault reports and plant levels are synchronous to clk and that
 * software reaches the registers over APB.
 */
`timescale 1ns/1ps

// Functional notes
// - accept only if idle or more important
// - priority-1 hardware trips never clear
// - priority-2 trips are non-resettable
// - memory trip needs load-defaults code first
// - card trips rank five during power-up
// - encoder supply overrides only minor encoder and under-voltage
// - extended-reset trips wait ten seconds
// - other trips wait one second
// - non-important trips stop first if enabled
// - overheat and phase loss stop first
// - under-voltage ignores user reset requests
// - under-voltage blocks only power stage
// - under-voltage saves unless low-voltage mode
// - supply recovery clears only under-voltage
// - supply switch only in under-voltage
// - under-voltage visible only when alone
// - power-up under-voltage skips the save
// - alarms flash 640 ms, program 10 s
// - no alarms while editing a parameter
// - brake alarm at 75.0 % when braking
// - motor alarm at 75 % when loaded
module trip_priority_alarm_manager #(
	parameter logic [31:0] RESET_DELAY = 32'(trip_pkg::RESET_DELAY_CYC),
	parameter logic [31:0] EXT_RESET_DELAY = 32'(trip_pkg::EXT_RESET_DELAY_CYC),
	parameter logic [31:0] STOP_TIMEOUT = 32'(trip_pkg::STOP_TIMEOUT_CYC),
	parameter logic [31:0] FLASH_PERIOD = 32'(trip_pkg::FLASH_CYC),
	parameter logic [31:0] PLC_PERIOD = 32'(trip_pkg::PLC_FLASH_CYC)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire trip_pkg::apb_req_t apb_req,
	output trip_pkg::apb_rsp_t apb_rsp,
	input wire trip_pkg::fault_t fault,
	input wire trip_pkg::plant_t plant,
	output logic trip_active,
	output logic [7:0] trip_code,
	output logic power_stage_en,
	output logic stop_req,
	output logic param_save,
	output logic supply_sel,
	output logic alarm_show
);
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_STOPPING = 2'b01
	} stop_state_t;

	typedef struct packed {
		trip_pkg::apb_rsp_t rsp;
		logic [trip_pkg::CTRL_W-1:0] ctrl;
		logic tripped;
		trip_pkg::trip_class_t cls;
		logic [2:0] prio;
		logic [7:0] code;
		logic [31:0] age;
		logic defaults_ok;
		logic reset_rejected;
		stop_state_t stop_st;
		trip_pkg::trip_class_t pend_cls;
		logic [7:0] pend_code;
		logic [31:0] stop_cnt;
		logic first;
		logic uv_prev;
		logic save;
		logic supply;
		logic [31:0] flash_cnt;
		logic [31:0] plc_cnt;
		logic show;
		logic power_en;
		logic stopping;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	// Priority of a class, with card trips demoted while powering up.
	function automatic logic [2:0] prio_of(input trip_pkg::trip_class_t c, input logic pup);
		logic [2:0] p;
		p = trip_pkg::PRIO_NORMAL;
		case (c)
			trip_pkg::CL_HW: p = trip_pkg::PRIO_HW;
			trip_pkg::CL_NONRES: p = trip_pkg::PRIO_NONRES;
			trip_pkg::CL_MEM: p = trip_pkg::PRIO_MEM;
			trip_pkg::CL_CARD: p = pup ? trip_pkg::PRIO_NORMAL : trip_pkg::PRIO_CARD;
			trip_pkg::CL_ENC_SUPPLY: p = trip_pkg::PRIO_CARD;
			trip_pkg::CL_UV: p = trip_pkg::PRIO_UV;
			default: p = trip_pkg::PRIO_NORMAL;
		endcase
		return p;
	endfunction : prio_of

	logic uv_cond;
	logic [2:0] in_prio;
	logic accept_ok;
	logic stop_first;
	logic wr_acc;
	logic reset_req;
	logic reset_ok;
	logic [31:0] delay;
	logic brake_alarm;
	logic motor_alarm;
	logic any_alarm;
	logic [31:0] rdata;
	logic rd_err;

	// Acceptance test for an incoming fault against the latched trip.
	always_comb
	begin
		uv_cond = ~plant.dc_bus_ok;
		in_prio = prio_of(fault.cls, state_r.ctrl[trip_pkg::CTRL_POWER_UP]);
		accept_ok = ~state_r.tripped | (state_r.prio > in_prio);
		// Encoder supply trips may only displace the minor encoder and under-voltage trips.
		if (state_r.tripped && fault.cls == trip_pkg::CL_ENC_SUPPLY
			&& state_r.prio == trip_pkg::PRIO_NORMAL
			&& state_r.cls != trip_pkg::CL_ENC_MINOR)
		begin
			accept_ok = 1'b0;
		end
		stop_first = (fault.cls == trip_pkg::CL_PHASE)
			| (fault.cls == trip_pkg::CL_OVERHEAT)
			| (fault.cls == trip_pkg::CL_NONIMP
				& state_r.ctrl[trip_pkg::CTRL_STOP_FIRST]);
	end

	// Reset eligibility of the latched trip.
	always_comb
	begin
		wr_acc = apb_req.psel & apb_req.penable & state_r.rsp.pready & apb_req.pwrite;
		reset_req = wr_acc & (apb_req.paddr == trip_pkg::ADDR_RESET)
			& apb_req.pwdata[trip_pkg::RST_REQ_BIT];
		delay = (state_r.cls == trip_pkg::CL_EXT_RESET) ? EXT_RESET_DELAY : RESET_DELAY;
		reset_ok = state_r.tripped & (state_r.age >= delay);
		case (state_r.cls)
			trip_pkg::CL_HW: reset_ok = 1'b0;
			trip_pkg::CL_NONRES: reset_ok = 1'b0;
			trip_pkg::CL_UV: reset_ok = 1'b0;
			trip_pkg::CL_MEM: reset_ok = reset_ok & state_r.defaults_ok;
			default: reset_ok = reset_ok;
		endcase
	end

	// Heating channels side by side: index 0 is the brake resistor, 1 the motor.
	// Each is qualified by its own activity, so an idle channel never warns.
	logic [1:0] heat_qual;
	logic [1:0][15:0] heat_acc;
	logic [1:0][15:0] heat_lim;
	logic [1:0] heat_hit;
	assign heat_qual = {plant.drive_loaded, plant.brake_active};
	assign heat_acc = {plant.motor_acc, plant.brake_acc};
	assign heat_lim = {plant.motor_limit, plant.brake_limit};

	// Alarm at three quarters of the trip level, compared as acc * 4 >= limit * 3.
	// Two guard bits keep the scaled products from overflowing at full scale.
	for (genvar g = 0; g < $bits(heat_hit); g++)
	begin : g_heat
		assign heat_hit[g] = heat_qual[g]
			& ({2'h0, heat_acc[g]} * trip_pkg::ALARM_DEN
				>= {2'h0, heat_lim[g]} * trip_pkg::ALARM_NUM);
	end

	// Named alarms for the register view and the flash logic.
	always_comb
	begin
		brake_alarm = heat_hit[0];
		motor_alarm = heat_hit[1];
		any_alarm = brake_alarm | motor_alarm | plant.limit_active;
	end

	// Read data mux, prepared in the setup phase.
	// Status is therefore that of the setup cycle, one cycle before the access.
	always_comb
	begin
		rdata = 32'h00000000;
		rd_err = 1'b0;
		case (apb_req.paddr)
			trip_pkg::ADDR_CTRL: rdata = {25'h0, state_r.ctrl};
			trip_pkg::ADDR_STATUS: rdata = {16'h0000, state_r.reset_rejected, state_r.supply,
				state_r.stop_st == ST_STOPPING, uv_cond, state_r.prio, state_r.tripped,
				state_r.code};
			trip_pkg::ADDR_RESET: rdata = 32'h00000000;
			trip_pkg::ADDR_DEFAULTS: rdata = {31'h0, state_r.defaults_ok};
			trip_pkg::ADDR_ALARMS: rdata = {28'h0000000, state_r.ctrl[trip_pkg::CTRL_PLC_RUN],
				plant.limit_active, motor_alarm, brake_alarm};
			default: rd_err = 1'b1;
		endcase
	end

	// Next-state logic for the whole block.
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.save = 1'b0;
		state_nxt.first = 1'b0;
		state_nxt.uv_prev = uv_cond;

		// APB: answer one cycle after setup, so every access has one wait-free access phase.
		state_nxt.rsp.pready = apb_req.psel & ~apb_req.penable;
		if (apb_req.psel && !apb_req.penable)
		begin
			state_nxt.rsp.prdata = apb_req.pwrite ? 32'h00000000 : rdata;
			state_nxt.rsp.pslverr = rd_err;
		end
		else
		begin
			state_nxt.rsp.prdata = 32'h00000000;
			state_nxt.rsp.pslverr = 1'b0;
		end

		// Register writes take effect at the completing access edge.
		if (wr_acc && apb_req.paddr == trip_pkg::ADDR_CTRL)
		begin
			state_nxt.ctrl = apb_req.pwdata[trip_pkg::CTRL_W-1:0];
		end
		if (wr_acc && apb_req.paddr == trip_pkg::ADDR_DEFAULTS
			&& apb_req.pwdata[15:0] == trip_pkg::LOAD_DEFAULTS_CODE)
		begin
			state_nxt.defaults_ok = 1'b1;
		end

		// Supply source follows the request only in the under-voltage condition.
		if (uv_cond)
		begin
			state_nxt.supply = state_r.ctrl[trip_pkg::CTRL_SUPPLY_SEL];
		end

		// Age of the latched trip, saturating so it never wraps back below a delay.
		if (state_r.tripped && state_r.age != 32'hFFFFFFFF)
		begin
			state_nxt.age = state_r.age + 32'h00000001;
		end

		// User reset; a refused attempt is recorded until the next good one.
		if (reset_req)
		begin
			if (reset_ok)
			begin
				state_nxt.tripped = 1'b0;
				state_nxt.prio = trip_pkg::PRIO_NONE;
				state_nxt.code = 8'h00;
				state_nxt.reset_rejected = 1'b0;
				if (state_r.cls == trip_pkg::CL_MEM)
				begin
					state_nxt.defaults_ok = 1'b0;
				end
			end
			else
			begin
				state_nxt.reset_rejected = 1'b1;
			end
		end

		// Self-reset of the under-voltage trip once the bus recovers.
		if (!uv_cond && state_r.tripped && state_r.cls == trip_pkg::CL_UV)
		begin
			state_nxt.tripped = 1'b0;
			state_nxt.prio = trip_pkg::PRIO_NONE;
			state_nxt.code = 8'h00;
		end

		// Stop-before-trip sequence; the overheat case is forced after a timeout.
		case (state_r.stop_st)
			ST_RUN:
			begin
				state_nxt.stop_cnt = 32'h00000000;
			end
			ST_STOPPING:
			begin
				state_nxt.stop_cnt = state_r.stop_cnt + 32'h00000001;
				if (plant.motor_stopped
					|| (state_r.pend_cls == trip_pkg::CL_OVERHEAT
						&& state_r.stop_cnt >= STOP_TIMEOUT - 32'h00000001))
				begin
					state_nxt.stop_st = ST_RUN;
					if (~state_r.tripped | (state_r.prio > trip_pkg::PRIO_NORMAL))
					begin
						state_nxt.tripped = 1'b1;
						state_nxt.cls = state_r.pend_cls;
						state_nxt.prio = trip_pkg::PRIO_NORMAL;
						state_nxt.code = state_r.pend_code;
						state_nxt.age = 32'h00000000;
					end
				end
			end
			default: state_nxt.stop_st = ST_RUN;
		endcase

		// Under-voltage trip raised on entry to the condition, or at power-up.
		if (uv_cond && (!state_r.uv_prev || state_r.first) && !state_nxt.tripped)
		begin
			state_nxt.tripped = 1'b1;
			state_nxt.cls = trip_pkg::CL_UV;
			state_nxt.prio = trip_pkg::PRIO_UV;
			state_nxt.code = trip_pkg::UV_CODE;
			state_nxt.age = 32'h00000000;
			state_nxt.save = ~state_r.first & ~state_r.ctrl[trip_pkg::CTRL_LV_MODE];
		end

		// A new fault from the drive, accepted by priority.
		if (fault.valid && accept_ok)
		begin
			if (stop_first && state_r.stop_st == ST_RUN)
			begin
				state_nxt.stop_st = ST_STOPPING;
				state_nxt.pend_cls = fault.cls;
				state_nxt.pend_code = fault.code;
			end
			else if (!stop_first)
			begin
				state_nxt.tripped = 1'b1;
				state_nxt.cls = fault.cls;
				state_nxt.prio = in_prio;
				state_nxt.code = fault.code;
				state_nxt.age = 32'h00000000;
				state_nxt.stop_st = ST_RUN;
			end
		end

		// Power stage is blocked by any trip, including under-voltage.
		state_nxt.power_en = state_r.ctrl[trip_pkg::CTRL_DRIVE_EN]
			& ~state_nxt.tripped & ~uv_cond;

		// The stop request leaves from its own flip-flop, not from a decode of
		// the sequence state, so the pin cannot glitch when the state moves.
		state_nxt.stopping = state_nxt.stop_st == ST_STOPPING;

		// Flash timing: shown in the first 320 ms of each 640 ms window, and
		// the program alarm for one 640 ms slot in each 10 s.
		state_nxt.flash_cnt = (state_r.flash_cnt >= FLASH_PERIOD - 32'h00000001)
			? 32'h00000000 : state_r.flash_cnt + 32'h00000001;
		state_nxt.plc_cnt = (state_r.plc_cnt >= PLC_PERIOD - 32'h00000001)
			? 32'h00000000 : state_r.plc_cnt + 32'h00000001;
		state_nxt.show = ~state_r.ctrl[trip_pkg::CTRL_EDITING]
			& ((any_alarm & (state_r.flash_cnt < (FLASH_PERIOD >> 1)))
			| (state_r.ctrl[trip_pkg::CTRL_PLC_RUN] & (state_r.plc_cnt < FLASH_PERIOD)));
	end

	// Single state register; everything comes up idle and untripped.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= '0;
			state_r.ctrl <= trip_pkg::CTRL_RESET_VAL;
			state_r.prio <= trip_pkg::PRIO_NONE;
			state_r.cls <= trip_pkg::CL_NORMAL;
			state_r.pend_cls <= trip_pkg::CL_NORMAL;
			state_r.stop_st <= ST_RUN;
			state_r.first <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register.
	assign apb_rsp = state_r.rsp;
	assign trip_active = state_r.tripped;
	assign trip_code = state_r.code;
	assign power_stage_en = state_r.power_en;
	assign stop_req = state_r.stopping;
	assign param_save = state_r.save;
	assign supply_sel = state_r.supply;
	assign alarm_show = state_r.show;
endmodule : trip_priority_alarm_manager

// File: trip_checker_sva.sv
/* Port checker for the trip supervisor, bound to its top module.
   Assumes the bind hands on the stop timeout in clock cycles. */
`timescale 1ns/1ps
module trip_checker #(
	parameter int STOP_TIMEOUT = 40
) (
	input wire logic clk,
	input wire logic resetn,
	input wire trip_pkg::apb_req_t apb_req,
	input wire trip_pkg::apb_rsp_t apb_rsp,
	input wire trip_pkg::fault_t fault,
	input wire trip_pkg::plant_t plant,
	input wire logic trip_active,
	input wire logic [7:0] trip_code,
	input wire logic power_stage_en,
	input wire logic stop_req,
	input wire logic param_save,
	input wire logic supply_sel,
	input wire logic alarm_show
);
	localparam int STOP_MAX = STOP_TIMEOUT + 4;
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// A report of one class arriving while nothing is latched or stopping.
	sequence idle_take(trip_pkg::trip_class_t c);
		fault.valid && fault.cls == c && !trip_active && !stop_req;
	endsequence
	// A hardware fault report followed by a latched trip.
	sequence hw_held;
		fault.valid && fault.cls == trip_pkg::CL_HW ##1 trip_active;
	endsequence
	AST_ACCEPT: assert property (
		idle_take(trip_pkg::CL_NORMAL) |=> trip_active && trip_code == $past(fault.code))
		else $error("Idle fault not latched.");
	AST_HW_HOLD: assert property (hw_held |=> trip_active[*8])
		else $error("Hardware trip cleared.");
	AST_PHASE_STOP: assert property (
		idle_take(trip_pkg::CL_PHASE) |=> stop_req && !trip_active)
		else $error("Phase loss did not stop first.");
	AST_OVH_FORCE: assert property (
		idle_take(trip_pkg::CL_OVERHEAT) |-> ##[1:STOP_MAX] trip_active)
		else $error("Overheat trip not forced.");
	AST_SAVE_UV: assert property (
		param_save |-> trip_active && trip_code == trip_pkg::UV_CODE)
		else $error("Save outside under-voltage.");
	AST_PSE_UV: assert property (!plant.dc_bus_ok |=> !power_stage_en)
		else $error("Power stage on in under-voltage.");
	AST_UV_CLEAR: assert property (
		$rose(plant.dc_bus_ok) && trip_active && trip_code == trip_pkg::UV_CODE
		|-> ##[1:3] !trip_active)
		else $error("Under-voltage trip not cleared.");
	AST_OTHER_HOLD: assert property (
		trip_active && trip_code != trip_pkg::UV_CODE && !apb_req.psel
		&& !$past(apb_req.psel) |=> trip_active)
		else $error("Trip cleared without a reset.");
endmodule : trip_checker

bind trip_priority_alarm_manager trip_checker #(.STOP_TIMEOUT(STOP_TIMEOUT)) u_chk (
	.clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.fault(fault), .plant(plant), .trip_active(trip_active), .trip_code(trip_code),
	.power_stage_en(power_stage_en), .stop_req(stop_req), .param_save(param_save),
	.supply_sel(supply_sel), .alarm_show(alarm_show));

// File: motor_model.sv
/* Motor at the drive's far side: it comes to rest after a stop request.
   Assumes the bench sets slow to model a motor that never stops. */
`timescale 1ns/1ps
module motor_model (
	input wire logic clk,
	input wire logic stop_req,
	input wire logic slow,
	output logic motor_stopped
);
	logic [3:0] cnt_r;
	// Coasting takes a few cycles, so the stop is never instant.
	always_ff @(posedge clk)
	begin
		cnt_r <= stop_req ? cnt_r + 4'h1 : 4'h0;
		motor_stopped <= stop_req && !slow && cnt_r == 4'h5;
	end
endmodule : motor_model

// File: trip_priority_alarm_manager_tb_top.sv
/* Self-checking bench for the trip supervisor: APB tasks, fault pulses
   and plant levels. Assumes the motor model answers stop requests. */
`timescale 1ns/1ps
module trip_priority_alarm_manager_tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic slow = 1'b0;
	logic ms, ta, ps, sr, sv, ss, al, er;
	logic [7:0] tc;
	logic [31:0] q;
	trip_pkg::apb_req_t rq = '0;
	trip_pkg::apb_rsp_t rs;
	trip_pkg::fault_t ft = '0;
	trip_pkg::plant_t pl = '0;
	trip_pkg::plant_t pw;
	int mismatches = 0;
	int n_checks = 0;
	int saves = 0;
	// A 4 ns period.
	always #2 clk = ~clk;
	// The stop flag belongs to the motor model.
	always_comb
	begin
		pw = pl;
		pw.motor_stopped = ms;
	end
	// Save pulses are counted away from the edge that makes them; an unknown counts too.
	always @(negedge clk) saves += int'(sv !== 1'b0);
	// Short counts keep the run brief; expectations follow them.
	trip_priority_alarm_manager #(.RESET_DELAY(32'h14), .EXT_RESET_DELAY(32'h32),
		.STOP_TIMEOUT(32'h28), .FLASH_PERIOD(32'h8), .PLC_PERIOD(32'h40)) u_dut (
		.clk(clk), .resetn(resetn), .apb_req(rq), .apb_rsp(rs), .fault(ft), .plant(pw),
		.trip_active(ta), .trip_code(tc), .power_stage_en(ps), .stop_req(sr),
		.param_save(sv), .supply_sel(ss), .alarm_show(al));
	motor_model u_mot (.clk(clk), .stop_req(sr), .slow(slow), .motor_stopped(ms));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// One APB transfer; pready and the answer are taken at the rising edge
	// that completes the access, and only then is the request released.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		rq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		rq.penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (rs.pready !== 1'b1 && i < 20);
		if (rs.pready !== 1'b1)
		begin
			mismatches++;
			complete_run();
		end
		q = rs.prdata;
		er = rs.pslverr;
		rq.psel <= 1'b0;
		rq.penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic stat(input logic [8:0] e);
		apb(1'b0, trip_pkg::ADDR_STATUS, 32'h0);
		chk("status", q[8:0], e);
		chk("pins", {ta, tc}, e);
	endtask : stat
	task automatic clr;
		cyc(24);
		wr(trip_pkg::ADDR_RESET, 32'h1);
	endtask : clr
	task automatic flt(input trip_pkg::trip_class_t c, input logic [7:0] d);
		@(posedge clk);
		ft <= '{1'b1, c, d};
		@(posedge clk);
		ft.valid <= 1'b0;
	endtask : flt
	// Registered outputs follow a register write one edge late.
	task automatic pin(input string n, ref logic s, input logic e);
		@(posedge clk);
		@(negedge clk);
		chk(n, s, e);
		@(posedge clk);
	endtask : pin
	// Counts flash-phase cycles over one slow period.
	task automatic flash(input logic [31:0] c, input int e);
		int n;
		n = 0;
		wr(trip_pkg::ADDR_CTRL, c);
		cyc(4);
		repeat (64)
		begin
			@(negedge clk);
			n += int'(al !== 1'b0);
		end
		@(posedge clk);
		chk("flash", n, e);
	endtask : flash
	// Main sequence; power comes up with the bus low.
	initial
	begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		stat({1'b1, trip_pkg::UV_CODE});
		chk("saves", saves, 0);
		clr();
		stat({1'b1, trip_pkg::UV_CODE});
		pl.dc_bus_ok <= 1'b1;
		cyc(3);
		stat(9'h000);
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", er, 1);
		flt(trip_pkg::CL_NORMAL, 8'h42);
		wr(trip_pkg::ADDR_RESET, 32'h1);
		stat(9'h142);
		clr();
		stat(9'h000);
		flt(trip_pkg::CL_EXT_RESET, 8'h43);
		cyc(30);
		wr(trip_pkg::ADDR_RESET, 32'h1);
		stat(9'h143);
		clr();
		stat(9'h000);
		for (int k = 0; k < 2; k++)
		begin
			flt(trip_pkg::CL_NORMAL, 8'h44);
			flt(trip_pkg::trip_class_t'(k), 8'h45);
			flt(trip_pkg::CL_NORMAL, 8'h46);
			stat(9'h145);
			clr();
			stat(9'h145);
			resetn <= 1'b0;
			cyc(2);
			resetn <= 1'b1;
		end
		for (int k = 0; k < 2; k++)
		begin
			wr(trip_pkg::ADDR_CTRL, 32'(k) << trip_pkg::CTRL_POWER_UP);
			flt(trip_pkg::CL_CARD, 8'h47);
			apb(1'b0, trip_pkg::ADDR_STATUS, 32'h0);
			chk("prio", q[11:9], 32'(trip_pkg::PRIO_CARD) + 32'(k));
			clr();
		end
		flt(trip_pkg::CL_ENC_MINOR, 8'h48);
		flt(trip_pkg::CL_ENC_SUPPLY, 8'h49);
		stat(9'h149);
		clr();
		flt(trip_pkg::CL_NORMAL, 8'h4A);
		flt(trip_pkg::CL_ENC_SUPPLY, 8'h49);
		stat(9'h14A);
		clr();
		flt(trip_pkg::CL_MEM, 8'h4B);
		clr();
		stat(9'h14B);
		wr(trip_pkg::ADDR_DEFAULTS, 32'(trip_pkg::LOAD_DEFAULTS_CODE));
		wr(trip_pkg::ADDR_RESET, 32'h1);
		stat(9'h000);
		// Without the stop-first bit a non-important trip latches at once.
		flt(trip_pkg::CL_NONIMP, 8'h51);
		pin("stop", sr, 1'b0);
		stat(9'h151);
		clr();
		// Stop-first classes; the last one meets a motor that never stops.
		wr(trip_pkg::ADDR_CTRL, 32'h1 << trip_pkg::CTRL_STOP_FIRST);
		for (int k = 0; k < 3; k++)
		begin
			slow <= (k == 2);
			flt(trip_pkg::trip_class_t'(4'h8 + 4'(k)), 8'h50);
			pin("stop", sr, 1'b1);
			cyc(25);
			apb(1'b0, trip_pkg::ADDR_STATUS, 32'h0);
			chk("early", q[8], 32'(k != 2));
			cyc(20);
			stat(9'h150);
			clr();
		end
		wr(trip_pkg::ADDR_CTRL, 32'h1 << trip_pkg::CTRL_DRIVE_EN);
		pin("stage", ps, 1'b1);
		pl.dc_bus_ok <= 1'b0;
		cyc(3);
		chk("saves", saves, 1);
		chk("stage", ps, 0);
		wr(trip_pkg::ADDR_CTRL, 32'h50);
		pin("supply", ss, 1'b1);
		pl.dc_bus_ok <= 1'b1;
		cyc(3);
		stat(9'h000);
		wr(trip_pkg::ADDR_CTRL, 32'h1 << trip_pkg::CTRL_LV_MODE);
		pin("supply", ss, 1'b1);
		pl.dc_bus_ok <= 1'b0;
		cyc(3);
		chk("saves", saves, 1);
		pl.dc_bus_ok <= 1'b1;
		cyc(3);
		flt(trip_pkg::CL_NORMAL, 8'h4C);
		pl.dc_bus_ok <= 1'b0;
		cyc(3);
		stat(9'h14C);
		pl.dc_bus_ok <= 1'b1;
		cyc(3);
		stat(9'h14C);
		clr();
		// Thresholds at 75 % of 100, then one below.
		pl.drive_loaded <= 1'b1;
		pl.brake_active <= 1'b1;
		pl.motor_limit <= 16'h0064;
		pl.brake_limit <= 16'h0064;
		for (int k = 0; k < 2; k++)
		begin
			pl.motor_acc <= 16'h004B - 16'(k);
			pl.brake_acc <= 16'h004B - 16'(k);
			cyc(2);
			apb(1'b0, trip_pkg::ADDR_ALARMS, 32'h0);
			chk("alarms", q[1:0], k ? 32'h0 : 32'h3);
		end
		pl.motor_acc <= 16'h004B;
		flash(32'h0, 32);
		flash(32'h1 << trip_pkg::CTRL_EDITING, 0);
		pl.motor_acc <= 16'h0000;
		pl.brake_acc <= 16'h0000;
		flash(32'h1 << trip_pkg::CTRL_PLC_RUN, 8);
		complete_run();
	end
endmodule : trip_priority_alarm_manager_tb_top
